/* verilog/reset_seq_pkg.sv */
package reset_seq_pkg;

	localparam int unsigned NUM_SRC         = 8;
	localparam int unsigned SRC_POWER_ON    = 0;
	localparam int unsigned SRC_EXT_PIN     = 1;
	localparam int unsigned SRC_COMPARATOR  = 2;
	localparam int unsigned SRC_SOFTWARE    = 3;
	localparam int unsigned SRC_SUPPLY_MON  = 4;
	localparam int unsigned SRC_WATCHDOG    = 5;
	localparam int unsigned SRC_MISSING_CLK = 6;
	localparam int unsigned SRC_FLASH_ERR   = 7;

	localparam logic [NUM_SRC-1:0] CAUSE_RESET = 8'h01;

	localparam int unsigned CLK_SRC_W          = 2;
	localparam logic [1:0]  CLK_SRC_HIGH_FREQ_OSC_24M = 2'h0;

	localparam int unsigned DIV_SEL_W   = 3;
	localparam int unsigned DIV_CNT_W   = 7;
	localparam logic [2:0]  DIV_SEL_DEFAULT = 3'h3;
	localparam logic [6:0]  DIV_CNT_RESET   = 7'h00;

	localparam int unsigned PC_W         = 16;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	localparam int unsigned HOLD_CNT_W      = 3;
	localparam logic [2:0]  MIN_HOLD_CYCLES = 3'h4;
	localparam logic [2:0]  HOLD_CNT_RESET  = 3'h0;

	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_HOLD = 3'b010,
		ST_EXIT = 3'b100
	} seq_state_t;

endpackage

/* verilog/system_reset_sequencer.sv */
module system_reset_sequencer
	import reset_seq_pkg::*;
(
	input  wire logic                              CORE_CLK_IN,
	input  wire logic                              SYS_RST_IN,
	input  wire logic                              POWER_ON_RST_IN,
	input  wire logic                              EXTERNAL_RESET_PIN_N_IN,
	input  wire logic                              COMPARATOR_RST_IN,
	input  wire logic                              SOFTWARE_RST_IN,
	input  wire logic                              SUPPLY_MON_RST_IN,
	input  wire logic                              WATCHDOG_RST_IN,
	input  wire logic                              MISSING_CLK_RST_IN,
	input  wire logic                              FLASH_ERR_RST_IN,
	input  wire logic                              RETAIN_SET_IN,
	input  wire logic                              RETAIN_CLR_IN,
	input  wire logic                              CLK_SRC_WR_IN,
	input  wire logic [reset_seq_pkg::CLK_SRC_W-1:0] CLK_SRC_SEL_IN,
	input  wire logic                              DIV_WR_IN,
	input  wire logic [reset_seq_pkg::DIV_SEL_W-1:0] DIV_SEL_IN,
	input  wire logic                              WDT_DISABLE_IN,
	output logic                                   CORE_HALT_OUT,
	output logic                                   MODULE_RST_OUT,
	output logic                                   POWER_UP_RST_OUT,
	output logic                                   PORT_DEFAULT_OUT,
	output logic                                   RETAIN_HOLD_OUT,
	output logic                                   RETAIN_ACTIVE_OUT,
	output logic                                   IRQ_TIMER_DISABLE_OUT,
	output logic                                   RAM_WRITE_INHIBIT_OUT,
	output logic                                   EXTERNAL_RESET_PIN_N_OUT,
	output logic                                   EXTERNAL_RESET_PIN_N_OE_N_OUT,
	output logic                                   PC_CLEAR_OUT,
	output logic [reset_seq_pkg::PC_W-1:0]         FETCH_ADDR_OUT,
	output logic                                   CORE_START_OUT,
	output logic [reset_seq_pkg::CLK_SRC_W-1:0]    CLK_SRC_SEL_OUT,
	output logic [reset_seq_pkg::DIV_SEL_W-1:0]    DIV_SEL_OUT,
	output logic                                   SYSCLK_TICK_OUT,
	output logic                                   WDT_ENABLE_OUT,
	output logic                                   WDT_RUN_OUT,
	output logic [reset_seq_pkg::NUM_SRC-1:0]      RESET_CAUSE_OUT
);
	import reset_seq_pkg::*;

	seq_state_t             state_q;
	seq_state_t             state_d;
	logic [NUM_SRC-1:0]     cause_q;
	logic [NUM_SRC-1:0]     cause_d;
	logic [HOLD_CNT_W-1:0]  hold_q;
	logic [HOLD_CNT_W-1:0]  hold_d;
	logic                   por_q;
	logic                   por_d;
	logic                   pin_drive_q;
	logic                   pin_drive_d;
	logic                   retain_q;
	logic                   retain_d;
	logic                   port_default_q;
	logic                   port_default_d;
	logic                   retain_hold_q;
	logic                   retain_hold_d;
	logic                   pc_clear_q;
	logic                   pc_clear_d;
	logic [PC_W-1:0]        fetch_q;
	logic [PC_W-1:0]        fetch_d;
	logic                   start_q;
	logic                   start_d;
	logic [CLK_SRC_W-1:0]   clk_src_q;
	logic [CLK_SRC_W-1:0]   clk_src_d;
	logic [DIV_SEL_W-1:0]   div_sel_q;
	logic [DIV_SEL_W-1:0]   div_sel_d;
	logic [DIV_CNT_W-1:0]   div_cnt_q;
	logic [DIV_CNT_W-1:0]   div_cnt_d;
	logic                   tick_q;
	logic                   tick_d;
	logic                   wdt_en_q;
	logic                   wdt_en_d;
	logic [NUM_SRC-1:0]     src;
	logic                   any_src;
	logic                   in_reset;
	logic [DIV_CNT_W-1:0]   div_limit;

	// Our own drive of the reset pin must not read back as an external request,
	// otherwise a power-on reset would hold itself forever
	always_comb begin
		src                  = '0;
		src[SRC_POWER_ON]    = POWER_ON_RST_IN;
		src[SRC_EXT_PIN]     = ~EXTERNAL_RESET_PIN_N_IN & ~pin_drive_q;
		src[SRC_COMPARATOR]  = COMPARATOR_RST_IN;
		src[SRC_SOFTWARE]    = SOFTWARE_RST_IN;
		src[SRC_SUPPLY_MON]  = SUPPLY_MON_RST_IN;
		src[SRC_WATCHDOG]    = WATCHDOG_RST_IN;
		src[SRC_MISSING_CLK] = MISSING_CLK_RST_IN;
		src[SRC_FLASH_ERR]   = FLASH_ERR_RST_IN;
		any_src              = |src;
	end

	assign in_reset = (state_q != ST_RUN);

	// Sequencer
	always_comb begin
		state_d = state_q;
		cause_d = cause_q;
		hold_d  = hold_q;
		por_d   = por_q;
		pin_drive_d = pin_drive_q;
		pc_clear_d  = 1'b0;
		start_d     = 1'b0;
		fetch_d     = fetch_q;
		case (state_q)
			ST_RUN: begin
				if (any_src) begin
					state_d     = ST_HOLD;
					cause_d     = src;
					hold_d      = HOLD_CNT_RESET;
					por_d       = src[SRC_POWER_ON];
					pin_drive_d = src[SRC_POWER_ON] | src[SRC_SUPPLY_MON];
				end
			end
			ST_HOLD: begin
				cause_d     = cause_q | src;
				por_d       = por_q | src[SRC_POWER_ON];
				pin_drive_d = pin_drive_q | src[SRC_POWER_ON] | src[SRC_SUPPLY_MON];
				if (hold_q != MIN_HOLD_CYCLES) begin
					hold_d = hold_q + 3'h1;
				end
				// Minimum hold lets a one-cycle software pulse still reach every module
				if (!any_src && (hold_q == MIN_HOLD_CYCLES)) begin
					state_d     = ST_EXIT;
					pin_drive_d = 1'b0;
					pc_clear_d  = 1'b1;
					fetch_d     = RESET_VECTOR;
				end
			end
			ST_EXIT: begin
				if (any_src) begin
					state_d     = ST_HOLD;
					cause_d     = cause_q | src;
					hold_d      = HOLD_CNT_RESET;
					por_d       = src[SRC_POWER_ON];
					pin_drive_d = src[SRC_POWER_ON] | src[SRC_SUPPLY_MON];
				end else begin
					state_d = ST_RUN;
					start_d = 1'b1;
				end
			end
			default: begin
				state_d = ST_HOLD;
				hold_d  = HOLD_CNT_RESET;
			end
		endcase
	end

	// Retention and port control
	always_comb begin
		retain_d = retain_q;
		if (RETAIN_SET_IN && !in_reset) begin
			retain_d = 1'b1;
		end else if (RETAIN_CLR_IN && !in_reset) begin
			retain_d = 1'b0;
		end
		// Only power-on clears retention; other resets keep the request alive
		if (state_d == ST_HOLD && (por_d || src[SRC_POWER_ON])) begin
			retain_d = 1'b0;
		end
		retain_hold_d  = (state_d != ST_RUN) & retain_d;
		port_default_d = (state_d != ST_RUN) & ~retain_d;
	end

	// Clock source, divider and watchdog
	always_comb begin
		clk_src_d = clk_src_q;
		div_sel_d = div_sel_q;
		wdt_en_d  = wdt_en_q;
		if (state_d != ST_RUN) begin
			clk_src_d = CLK_SRC_HIGH_FREQ_OSC_24M;
			div_sel_d = DIV_SEL_DEFAULT;
			wdt_en_d  = 1'b1;
		end else begin
			if (CLK_SRC_WR_IN) begin
				clk_src_d = CLK_SRC_SEL_IN;
			end
			if (DIV_WR_IN) begin
				div_sel_d = DIV_SEL_IN;
			end
			if (WDT_DISABLE_IN) begin
				wdt_en_d = 1'b0;
			end
		end
		div_limit = 7'((8'h01 << div_sel_q) - 8'h01);
		if (div_sel_d != div_sel_q || div_cnt_q >= div_limit) begin
			div_cnt_d = DIV_CNT_RESET;
		end else begin
			div_cnt_d = div_cnt_q + 7'h01;
		end
		tick_d = (div_sel_d == div_sel_q) && (div_cnt_q >= div_limit);
	end

	// SYS_RST_IN counts as a power-on: every flop, power-up-only ones included
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			state_q        <= ST_HOLD;
			cause_q        <= CAUSE_RESET;
			hold_q         <= HOLD_CNT_RESET;
			por_q          <= 1'b1;
			pin_drive_q    <= 1'b1;
			retain_q       <= 1'b0;
			port_default_q <= 1'b1;
			retain_hold_q  <= 1'b0;
			pc_clear_q     <= 1'b0;
			fetch_q        <= RESET_VECTOR;
			start_q        <= 1'b0;
			clk_src_q      <= CLK_SRC_HIGH_FREQ_OSC_24M;
			div_sel_q      <= DIV_SEL_DEFAULT;
			div_cnt_q      <= DIV_CNT_RESET;
			tick_q         <= 1'b0;
			wdt_en_q       <= 1'b1;
		end else begin
			state_q        <= state_d;
			cause_q        <= cause_d;
			hold_q         <= hold_d;
			por_q          <= por_d;
			pin_drive_q    <= pin_drive_d;
			retain_q       <= retain_d;
			port_default_q <= port_default_d;
			retain_hold_q  <= retain_hold_d;
			pc_clear_q     <= pc_clear_d;
			fetch_q        <= fetch_d;
			start_q        <= start_d;
			clk_src_q      <= clk_src_d;
			div_sel_q      <= div_sel_d;
			div_cnt_q      <= div_cnt_d;
			tick_q         <= tick_d;
			wdt_en_q       <= wdt_en_d;
		end
	end

	assign CORE_HALT_OUT         = in_reset;
	assign MODULE_RST_OUT        = (state_q == ST_HOLD);
	assign POWER_UP_RST_OUT      = (state_q == ST_HOLD) & por_q;
	assign IRQ_TIMER_DISABLE_OUT = in_reset;
	// Blocks stray writes while the core is halted; nothing here ever clears memory
	assign RAM_WRITE_INHIBIT_OUT = in_reset;
	assign PORT_DEFAULT_OUT      = port_default_q;
	assign RETAIN_HOLD_OUT       = retain_hold_q;
	assign RETAIN_ACTIVE_OUT     = retain_q;
	assign EXTERNAL_RESET_PIN_N_OUT      = 1'b0;
	assign EXTERNAL_RESET_PIN_N_OE_N_OUT = ~pin_drive_q;
	assign PC_CLEAR_OUT          = pc_clear_q;
	assign FETCH_ADDR_OUT        = fetch_q;
	assign CORE_START_OUT        = start_q;
	assign CLK_SRC_SEL_OUT       = clk_src_q;
	assign DIV_SEL_OUT           = div_sel_q;
	assign SYSCLK_TICK_OUT       = tick_q;
	assign WDT_ENABLE_OUT        = wdt_en_q;
	assign WDT_RUN_OUT           = wdt_en_q & ~in_reset;
	assign RESET_CAUSE_OUT       = cause_q;

endmodule // system_reset_sequencer

/* dv/reset_src_model.sv */
module reset_src_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] req_in,
	input  wire logic       pin_drv_in,
	input  wire logic       pin_oe_n_in,
	output logic      [7:0] src_out,
	output logic            pin_level_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial src_out = 8'h00;
	// Sources are level requests that change just after an edge
	always @(posedge clk_in) src_out <= req_in;
	// Open-drain line with a pull-up: low if the device or the board pulls it
	assign pin_level_out = !((!pin_oe_n_in && !pin_drv_in) || src_out[1]);
endmodule // reset_src_model

/* dv/system_reset_sequencer_chk.sv */
module system_reset_sequencer_chk
	import reset_seq_pkg::*;
(
	input wire logic                 CORE_CLK_IN,
	input wire logic                 SYS_RST_IN,
	input wire logic                 POWER_ON_RST_IN,
	input wire logic                 EXTERNAL_RESET_PIN_N_IN,
	input wire logic                 COMPARATOR_RST_IN,
	input wire logic                 SOFTWARE_RST_IN,
	input wire logic                 SUPPLY_MON_RST_IN,
	input wire logic                 WATCHDOG_RST_IN,
	input wire logic                 MISSING_CLK_RST_IN,
	input wire logic                 FLASH_ERR_RST_IN,
	input wire logic                 CORE_HALT_OUT,
	input wire logic                 MODULE_RST_OUT,
	input wire logic                 PORT_DEFAULT_OUT,
	input wire logic                 RETAIN_HOLD_OUT,
	input wire logic                 IRQ_TIMER_DISABLE_OUT,
	input wire logic                 RAM_WRITE_INHIBIT_OUT,
	input wire logic                 EXTERNAL_RESET_PIN_N_OE_N_OUT,
	input wire logic                 PC_CLEAR_OUT,
	input wire logic [PC_W-1:0]      FETCH_ADDR_OUT,
	input wire logic                 CORE_START_OUT,
	input wire logic [CLK_SRC_W-1:0] CLK_SRC_SEL_OUT,
	input wire logic [DIV_SEL_W-1:0] DIV_SEL_OUT,
	input wire logic                 WDT_RUN_OUT
);
	logic src_any;
	// The pin only counts while the device is not pulling it itself
	assign src_any = POWER_ON_RST_IN | COMPARATOR_RST_IN | SOFTWARE_RST_IN | SUPPLY_MON_RST_IN
		| WATCHDOG_RST_IN | MISSING_CLK_RST_IN | FLASH_ERR_RST_IN
		| (EXTERNAL_RESET_PIN_N_OE_N_OUT & !EXTERNAL_RESET_PIN_N_IN);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	property p_halt; !CORE_HALT_OUT && src_any |=> CORE_HALT_OUT && MODULE_RST_OUT; endproperty
	a_halt: assert property (p_halt) else $error("no halt after a source");
	property p_irq; CORE_HALT_OUT |-> IRQ_TIMER_DISABLE_OUT && !WDT_RUN_OUT; endproperty
	a_irq: assert property (p_irq) else $error("timers live in reset");
	property p_ram; RAM_WRITE_INHIBIT_OUT == CORE_HALT_OUT; endproperty
	a_ram: assert property (p_ram) else $error("ram guard wrong");
	property p_exit; PC_CLEAR_OUT && !src_any |=> CORE_START_OUT && !CORE_HALT_OUT
		&& FETCH_ADDR_OUT == RESET_VECTOR; endproperty
	a_exit: assert property (p_exit) else $error("bad start after exit");
	property p_ports; PORT_DEFAULT_OUT |-> !RETAIN_HOLD_OUT; endproperty
	a_ports: assert property (p_ports) else $error("ports forced while retained");
	property p_pin; !CORE_HALT_OUT && (POWER_ON_RST_IN || SUPPLY_MON_RST_IN)
		|=> !EXTERNAL_RESET_PIN_N_OE_N_OUT; endproperty
	a_pin: assert property (p_pin) else $error("reset pin not driven");
	property p_dflt; CORE_START_OUT |-> CLK_SRC_SEL_OUT == CLK_SRC_HIGH_FREQ_OSC_24M
		&& DIV_SEL_OUT == DIV_SEL_DEFAULT && WDT_RUN_OUT; endproperty
	a_dflt: assert property (p_dflt) else $error("defaults missing at start");
	property p_minhold; $rose(MODULE_RST_OUT) |-> MODULE_RST_OUT [*5]; endproperty
	a_minhold: assert property (p_minhold) else $error("hold too short");
	property p_rel; (MODULE_RST_OUT && !src_any) [*5] |=> !MODULE_RST_OUT; endproperty
	a_rel: assert property (p_rel) else $error("hold too long");
endmodule // system_reset_sequencer_chk
bind system_reset_sequencer system_reset_sequencer_chk u_chk (.CORE_CLK_IN, .SYS_RST_IN,
	.POWER_ON_RST_IN, .EXTERNAL_RESET_PIN_N_IN, .COMPARATOR_RST_IN, .SOFTWARE_RST_IN,
	.SUPPLY_MON_RST_IN, .WATCHDOG_RST_IN, .MISSING_CLK_RST_IN, .FLASH_ERR_RST_IN,
	.CORE_HALT_OUT, .MODULE_RST_OUT, .PORT_DEFAULT_OUT, .RETAIN_HOLD_OUT,
	.IRQ_TIMER_DISABLE_OUT, .RAM_WRITE_INHIBIT_OUT, .EXTERNAL_RESET_PIN_N_OE_N_OUT,
	.PC_CLEAR_OUT, .FETCH_ADDR_OUT, .CORE_START_OUT, .CLK_SRC_SEL_OUT, .DIV_SEL_OUT,
	.WDT_RUN_OUT);

/* dv/system_reset_sequencer_test.sv */
module system_reset_sequencer_test import reset_seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, rset = 0, rclr = 0, cwr = 0, dwr = 0, wdis = 0;
	logic [1:0] csel = 2'h0, csel_o;
	logic [2:0] dsel = 3'h0, dsel_o;
	logic [7:0] req = 8'h00, src, cause;
	logic [15:0] fetch;
	logic halt, mrst, pup, pdef, rhold, ract, irqd, pin, pin_o, oe_n, start, tick, wen;
	int num_errors = 0, check_count = 0, n;
	// Bit 8 marks sources that must pull the reset pin
	localparam logic [8:0] ROWS [8] = '{9'h101, 9'h002, 9'h004, 9'h008, 9'h110, 9'h020,
		9'h040, 9'h080};
	always #25 clk = ~clk;
	reset_src_model u_src (.clk_in(clk), .req_in(req), .pin_drv_in(pin_o),
		.pin_oe_n_in(oe_n), .src_out(src), .pin_level_out(pin));
	system_reset_sequencer u_dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
		.POWER_ON_RST_IN(src[0]), .EXTERNAL_RESET_PIN_N_IN(pin), .COMPARATOR_RST_IN(src[2]),
		.SOFTWARE_RST_IN(src[3]), .SUPPLY_MON_RST_IN(src[4]), .WATCHDOG_RST_IN(src[5]),
		.MISSING_CLK_RST_IN(src[6]), .FLASH_ERR_RST_IN(src[7]), .RETAIN_SET_IN(rset),
		.RETAIN_CLR_IN(rclr), .CLK_SRC_WR_IN(cwr), .CLK_SRC_SEL_IN(csel), .DIV_WR_IN(dwr),
		.DIV_SEL_IN(dsel), .WDT_DISABLE_IN(wdis), .CORE_HALT_OUT(halt), .MODULE_RST_OUT(mrst),
		.POWER_UP_RST_OUT(pup), .PORT_DEFAULT_OUT(pdef), .RETAIN_HOLD_OUT(rhold),
		.RETAIN_ACTIVE_OUT(ract), .IRQ_TIMER_DISABLE_OUT(irqd), .RAM_WRITE_INHIBIT_OUT(),
		.EXTERNAL_RESET_PIN_N_OUT(pin_o), .EXTERNAL_RESET_PIN_N_OE_N_OUT(oe_n),
		.PC_CLEAR_OUT(), .FETCH_ADDR_OUT(fetch), .CORE_START_OUT(start),
		.CLK_SRC_SEL_OUT(csel_o), .DIV_SEL_OUT(dsel_o), .SYSCLK_TICK_OUT(tick),
		.WDT_ENABLE_OUT(wen), .WDT_RUN_OUT(), .RESET_CAUSE_OUT(cause));
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t bit %b want %b", $time, got, exp);
		end
	endtask
	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t value %h want %h", $time, got, exp);
		end
	endtask
	// Returns one edge into the hold, where the reset outputs have settled
	task automatic pulse_src(input logic [7:0] v, input int len);
		@(posedge clk);
		req <= v;
		repeat (len) @(posedge clk);
		req <= 8'h00;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic wait_start();
		n = 0;
		while (start !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_bit(start, 1'b1);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#500us;
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1;
		chk_bit(pdef & pup & !oe_n, 1'b1);
		@(posedge clk);
		rst <= 0;
		wait_start();
		for (int i = 0; i < 8; i++) begin
			pulse_src(ROWS[i][7:0], 1);
			chk_bit(halt & mrst & irqd & pdef, 1'b1);
			chk_bit(oe_n, !ROWS[i][8]);
			wait_start();
			chk_vec(cause, ROWS[i][7:0]);
			chk_vec(fetch, RESET_VECTOR);
			$display("source %0d done", i);
		end
		// Source seen high up to one edge ago: the hold already ran out, so exit comes now
		pulse_src(8'h04, 12);
		chk_bit(halt & !mrst, 1'b1);
		wait_start();
		@(posedge clk);
		{rset, cwr, csel, wdis} <= 5'h1f;
		@(posedge clk);
		{rset, cwr, wdis} <= 3'h0;
		@(posedge clk);
		#1;
		chk_bit(ract & !wen, 1'b1);
		chk_vec(csel_o, 16'h0003);
		pulse_src(8'h08, 1);
		chk_bit(rhold & !pdef & !pup, 1'b1);
		wait_start();
		chk_vec({csel_o, dsel_o}, {CLK_SRC_HIGH_FREQ_OSC_24M, DIV_SEL_DEFAULT});
		chk_bit(wen & ract, 1'b1);
		pulse_src(8'h01, 1);
		chk_bit(pdef & pup, 1'b1);
		wait_start();
		chk_bit(ract, 1'b0);
		@(posedge clk);
		rset <= 1;
		@(posedge clk);
		rset <= 0;
		rclr <= 1;
		#1;
		chk_bit(ract, 1'b1);
		@(posedge clk);
		rclr <= 0;
		@(posedge clk);
		#1;
		chk_bit(ract, 1'b0);
		$display("retention done");
		for (int s = 0; s < 8; s++) begin
			@(posedge clk);
			dwr <= 1;
			dsel <= s[2:0];
			@(posedge clk);
			dwr <= 0;
			// Sample after the edge so the tick launched there is settled
			do begin
				@(posedge clk);
				#1;
			end while (tick !== 1'b1);
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (tick !== 1'b1 && n < 300);
			chk_vec(n[15:0], 16'h0001 << s);
		end
		$display("divider done");
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		#1;
		chk_bit(halt & pdef & pup & !oe_n, 1'b1);
		chk_vec(dsel_o, DIV_SEL_DEFAULT);
		@(posedge clk);
		rst <= 0;
		wait_start();
		chk_vec(cause, CAUSE_RESET);
		chk_bit(wen & !ract, 1'b1);
		$display("mid-run reset done");
		print_verdict();
	end
endmodule // system_reset_sequencer_test
